// file: acc_defs.svh
// register offsets, field positions, reset values and timing counts of the converter control
`ifndef ACC_DEFS_SVH
`define ACC_DEFS_SVH

`define ACC_ADDR_CONFIG       8'hBC
`define ACC_ADDR_CONTROL      8'hE8
`define ACC_ADDR_RESULT_LO    8'hBE
`define ACC_ADDR_RESULT_HI    8'hBF

`define ACC_CONFIG_RESET      8'h60
`define ACC_CONFIG_WR_MASK    8'hE7
`define ACC_CONTROL_RESET     8'h00

`define ACC_CTL_ENABLE_BIT    7
`define ACC_CTL_TRACK_BIT     6
`define ACC_CTL_DONE_BIT      5
`define ACC_CTL_BUSY_BIT      4
`define ACC_CTL_MODE_HI_BIT   3
`define ACC_CTL_MODE_LO_BIT   2
`define ACC_CTL_LJUST_BIT     0

`define ACC_CFG_CLKSEL_HI     7
`define ACC_CFG_CLKSEL_LO     5
`define ACC_CFG_GAIN_HI       2
`define ACC_CFG_GAIN_LO       0

`define ACC_SAR_BITS          10
`define ACC_TRACK_SAR_CLKS    2'd3
`define ACC_SYS_CLK_MHZ       50
`define ACC_SAR_CLK_MAX_MHZ   2
`define ACC_MAX_KSPS          100

`endif

// file: acc_pkg.sv
// types shared by the converter control
package acc_pkg;

    typedef enum logic [1:0] {
        ACC_IDLE  = 2'b00,
        ACC_TRACK = 2'b01,
        ACC_CONV  = 2'b10
    } acc_state_t;

    typedef enum logic [1:0] {
        ACC_START_SW   = 2'b00,
        ACC_START_TMR3 = 2'b01,
        ACC_START_EXT  = 2'b10,
        ACC_START_TMR2 = 2'b11
    } acc_start_t;

    typedef struct packed {
        logic       conv_enable;
        logic       track_mode;
        logic       conv_done_flag;
        logic       conv_busy;
        acc_start_t start_mode;
        logic       spare;
        logic       left_justify;
    } acc_ctrl_t;

    typedef struct packed {
        logic [2:0] sar_clock_period_sel;
        logic [1:0] unused;
        logic [2:0] amp_gain_sel;
    } acc_cfg_t;

endpackage

// file: acc_adc_control.sv
// conversion control: sar clock divider, start selection, track/convert sequencing, results
// What this block does
// [R1] sar clock period 1,2,4,8,16 system clocks
// [R2] software keeps sar clock at or below 2MHz; at 50MHz the slowest setting, 16, gives 3.125MHz
// [R3] supports up to 100ksps, no more required
// [R4] start-mode field picks one of four triggers
// [R5] software start: writing busy one starts conversion
// [R6] timer modes start on timer3/timer2 overflow
// [R7] external mode starts on convert-start rising edge
// [R8] busy high throughout conversion, low after
// [R9] busy falling sets done flag, requests interrupt
// [R10] software polls done flag, not busy
// [R11] result in high/low bytes, justified per bit
// [R12] tracking-mode clear: track except while converting
// [R13] low-power software start: track 3 sar clocks
// [R14] low-power timer start: track 3 sar clocks
// [R15] low-power external: track only while pin low
// [R16] tracking disabled in chip standby or sleep
// [R17] gain field decode 1,2,4,8,16,0.5
// [R18] config bits 4:3 read zero; reset 0x60
// [R19] analog runs only while enable bit set
// [R20] differential channels give two's complement results
// [R21] start modes: 00 sw,01 t3,10 ext,11 t2
// [R22] justification bit placement; unused bits zero, or sign copies when differential and right-justified
`timescale 1ns/1ps
`include "acc_defs.svh"

module acc_adc_control
    import acc_pkg::*;
(
    input  wire logic       clock,
    input  wire logic       rst,
    input  wire logic [7:0] sfr_addr,
    input  wire logic       sfr_wr,
    input  wire logic       sfr_rd,
    input  wire logic [7:0] sfr_wdata,
    output logic      [7:0] sfr_rdata,
    input  wire logic       tmr3_ovf,
    input  wire logic       tmr2_ovf,
    input  wire logic       ext_conv_start,
    input  wire logic       comp_in,
    input  wire logic       diff_mode,
    input  wire logic       chip_standby,
    output logic      [9:0] dac_code,
    output logic            sar_clk_tick,
    output logic            track_en,
    output logic            afe_enable,
    output logic      [2:0] pga_gain,
    output logic            conv_irq
);

    acc_cfg_t   cfg_q;
    acc_ctrl_t  ctl_q;
    acc_state_t state_q;
    acc_ctrl_t  wr_ctl;
    logic [3:0] div_cnt_q;
    logic [3:0] div_max;
    logic       tick;
    logic [2:0] ext_sync_q;
    logic       ext_rise;
    logic       start_req;
    logic       sw_start;
    logic [1:0] trk_cnt_q;
    logic [3:0] bit_idx_q;
    logic [9:0] sar_q;
    logic [9:0] sar_d;
    logic [9:0] res_val;
    logic [7:0] res_hi_q;
    logic [7:0] res_lo_q;
    logic       busy;
    logic       busy_d1_q;
    logic       busy_fall;
    logic       ctl_wr;
    logic       conv_last;
    logic [7:0] rd_mux;

    assign ctl_wr = sfr_wr && (sfr_addr == `ACC_ADDR_CONTROL);
    assign wr_ctl = acc_ctrl_t'(sfr_wdata);
    assign busy   = (state_q != ACC_IDLE);

    // config register, bits 4:3 held at zero
    always_ff @(posedge clock)
    begin
        if (rst)
            cfg_q <= acc_cfg_t'(`ACC_CONFIG_RESET);   // [R18]
        else if (sfr_wr && sfr_addr == `ACC_ADDR_CONFIG)
            cfg_q <= acc_cfg_t'(sfr_wdata & `ACC_CONFIG_WR_MASK);   // [R18]
    end

    // divider: 1xx saturates at 16
    always_comb
    begin
        case (cfg_q.sar_clock_period_sel)
            3'b000:  div_max = 4'h0;   // [R1]
            3'b001:  div_max = 4'h1;
            3'b010:  div_max = 4'h3;
            3'b011:  div_max = 4'h7;
            default: div_max = 4'hF;
        endcase
    end

    assign tick = (div_cnt_q >= div_max);

    // divider free-runs only while a conversion sequence is active
    always_ff @(posedge clock)
    begin
        if (rst || !busy || tick)
            div_cnt_q <= 4'h0;   // [R1]
        else
            div_cnt_q <= div_cnt_q + 4'h1;
    end

    always_ff @(posedge clock)
    begin
        if (rst)
            sar_clk_tick <= 1'b0;
        else
            sar_clk_tick <= busy && tick;
    end

    // pin synchroniser, edge taken after the second stage
    always_ff @(posedge clock)
    begin
        if (rst)
            ext_sync_q <= 3'h0;
        else
            ext_sync_q <= {ext_sync_q[1:0], ext_conv_start};
    end

    assign ext_rise = ext_sync_q[1] && !ext_sync_q[2];   // [R7]
    assign sw_start = ctl_wr && wr_ctl.conv_busy;   // [R5]

    // triggers while busy are dropped: no queue of pending starts
    always_comb
    begin
        case (ctl_q.start_mode)   // [R4] [R21]
            ACC_START_SW:   start_req = sw_start;   // [R5]
            ACC_START_TMR3: start_req = tmr3_ovf;   // [R6]
            ACC_START_EXT:  start_req = ext_rise;   // [R7]
            ACC_START_TMR2: start_req = tmr2_ovf;   // [R6]
            default:        start_req = 1'b0;
        endcase
    end

    assign conv_last = (state_q == ACC_CONV) && tick && (bit_idx_q == 4'h0);

    // sequencer; 3 track + 10 bit clocks take 6.5us at 2MHz, fast enough for 100ksps [R3]
    always_ff @(posedge clock)
    begin
        if (rst || !ctl_q.conv_enable)
            state_q <= ACC_IDLE;   // [R19]
        else
        begin
            case (state_q)
                ACC_IDLE:
                    if (start_req)
                    begin
                        if (ctl_q.track_mode && ctl_q.start_mode != ACC_START_EXT)
                            state_q <= ACC_TRACK;   // [R13] [R14]
                        else
                            state_q <= ACC_CONV;   // [R12] [R15]
                    end
                ACC_TRACK:
                    if (tick && trk_cnt_q == `ACC_TRACK_SAR_CLKS - 2'd1)
                        state_q <= ACC_CONV;   // [R13] [R14]
                ACC_CONV:
                    if (conv_last)
                        state_q <= ACC_IDLE;   // [R8]
                default:
                    state_q <= ACC_IDLE;
            endcase
        end
    end

    always_ff @(posedge clock)
    begin
        if (rst || state_q != ACC_TRACK)
            trk_cnt_q <= 2'd0;
        else if (tick)
            trk_cnt_q <= trk_cnt_q + 2'd1;   // [R13] [R14]
    end

    // dac_code copies the next trial word, so comp_in always judges sar_q;
    // a delayed copy would let a 1-clock sar period judge a stale code
    always_comb
    begin
        sar_d = sar_q;
        if (state_q != ACC_CONV)
            sar_d = 10'h200;
        else if (tick)
        begin
            sar_d[bit_idx_q] = comp_in;
            if (bit_idx_q != 4'h0)
                sar_d[bit_idx_q - 4'h1] = 1'b1;
        end
    end

    always_ff @(posedge clock)
    begin
        if (rst)
        begin
            sar_q     <= 10'h000;
            dac_code  <= 10'h000;
            bit_idx_q <= 4'h0;
        end
        else
        begin
            sar_q    <= sar_d;
            dac_code <= sar_d;
            if (state_q != ACC_CONV)
                bit_idx_q <= 4'(`ACC_SAR_BITS - 1);
            else if (tick && bit_idx_q != 4'h0)
                bit_idx_q <= bit_idx_q - 4'h1;
        end
    end

    // final word includes the last decided bit
    always_comb
    begin
        res_val = sar_q;
        res_val[0] = comp_in;
        if (diff_mode)
            res_val[9] = ~res_val[9];   // [R20]
    end

    always_ff @(posedge clock)
    begin
        if (rst)
        begin
            res_hi_q <= 8'h00;
            res_lo_q <= 8'h00;
        end
        else if (conv_last)
        begin
            if (ctl_q.left_justify)
            begin
                res_hi_q <= res_val[9:2];   // [R11] [R22]
                res_lo_q <= {res_val[1:0], 6'h00};
            end
            else
            begin
                res_hi_q <= {{6{diff_mode & res_val[9]}}, res_val[9:8]};   // [R20] [R22]
                res_lo_q <= res_val[7:0];   // [R11]
            end
        end
    end

    always_ff @(posedge clock)
    begin
        if (rst)
            busy_d1_q <= 1'b0;
        else
            busy_d1_q <= busy;
    end

    assign busy_fall = busy_d1_q && !busy;   // [R9]

    // control register; done flag set wins over a software clear
    always_ff @(posedge clock)
    begin
        if (rst)
            ctl_q <= acc_ctrl_t'(`ACC_CONTROL_RESET);
        else
        begin
            if (ctl_wr)
            begin
                ctl_q.conv_enable    <= wr_ctl.conv_enable;
                ctl_q.track_mode     <= wr_ctl.track_mode;
                ctl_q.start_mode     <= wr_ctl.start_mode;
                ctl_q.left_justify   <= wr_ctl.left_justify;
                ctl_q.spare          <= 1'b0;
                ctl_q.conv_done_flag <= wr_ctl.conv_done_flag;
            end
            if (busy_fall)
                ctl_q.conv_done_flag <= 1'b1;   // [R9]
            ctl_q.conv_busy <= busy;   // [R8]
        end
    end

    always_ff @(posedge clock)
    begin
        if (rst)
            conv_irq <= 1'b0;
        else
            conv_irq <= busy_fall;   // [R9]
    end

    // track-and-hold and front-end power
    always_ff @(posedge clock)
    begin
        if (rst)
        begin
            track_en   <= 1'b0;
            afe_enable <= 1'b0;
        end
        else
        begin
            afe_enable <= ctl_q.conv_enable;   // [R19]
            if (!ctl_q.conv_enable || chip_standby)
                track_en <= 1'b0;   // [R16] [R19]
            else if (!ctl_q.track_mode)
                track_en <= (state_q != ACC_CONV);   // [R12]
            else if (ctl_q.start_mode == ACC_START_EXT)
                track_en <= !ext_sync_q[1] && (state_q == ACC_IDLE);   // [R15]
            else
                track_en <= (state_q == ACC_TRACK);   // [R13] [R14]
        end
    end

    // gain code: 0..4 = x1..x16, 5 = x0.5
    always_ff @(posedge clock)
    begin
        if (rst)
            pga_gain <= 3'h0;
        else if (cfg_q.amp_gain_sel[2])
            pga_gain <= cfg_q.amp_gain_sel[1] ? 3'h5 : 3'h4;   // [R17]
        else
            pga_gain <= {1'b0, cfg_q.amp_gain_sel[1:0]};   // [R17]
    end

    always_comb
    begin
        case (sfr_addr)
            `ACC_ADDR_CONFIG:    rd_mux = cfg_q;   // [R18]
            `ACC_ADDR_CONTROL:   rd_mux = ctl_q;
            `ACC_ADDR_RESULT_HI: rd_mux = res_hi_q;
            `ACC_ADDR_RESULT_LO: rd_mux = res_lo_q;
            default:             rd_mux = 8'h00;
        endcase
    end

    always_ff @(posedge clock)
    begin
        if (rst)
            sfr_rdata <= 8'h00;
        else if (sfr_rd)
            sfr_rdata <= rd_mux;
    end

    a_cfg_reserved_zero: assert property (@(posedge clock) disable iff (rst) // [R18]
        cfg_q.unused == 2'b00) else $error("config reserved bits not zero");

    a_div_period_16: assert property (@(posedge clock) disable iff (rst) // [R1]
        cfg_q.sar_clock_period_sel[2] && tick |-> div_cnt_q == 4'hF)
        else $error("1xx divider not 16");

    a_sw_start_go: assert property (@(posedge clock) disable iff (rst) // [R5]
        (state_q == ACC_IDLE && ctl_q.conv_enable && ctl_q.start_mode == ACC_START_SW
         && sw_start) |=> busy) else $error("software start ignored");

    a_tmr3_start_go: assert property (@(posedge clock) disable iff (rst) // [R6]
        (state_q == ACC_IDLE && ctl_q.conv_enable && ctl_q.start_mode == ACC_START_TMR3
         && tmr3_ovf) |=> busy) else $error("timer 3 start ignored");

    a_ext_edge_go: assert property (@(posedge clock) disable iff (rst) // [R7]
        (state_q == ACC_IDLE && ctl_q.conv_enable && ctl_q.start_mode == ACC_START_EXT
         && ext_rise) |=> state_q == ACC_CONV) else $error("external edge ignored");

    a_busy_mirrors: assert property (@(posedge clock) disable iff (rst) // [R8]
        busy |=> ctl_q.conv_busy) else $error("busy bit not set during conversion");

    a_done_on_fall: assert property (@(posedge clock) disable iff (rst) // [R9]
        busy_fall |=> ctl_q.conv_done_flag && conv_irq) else $error("done flag not raised");

    a_track_three: assert property (@(posedge clock) disable iff (rst) // [R13]
        (state_q == ACC_IDLE && $past(state_q) == ACC_IDLE) ##1 state_q == ACC_TRACK
        |-> state_q == ACC_TRACK [*3]) else $error("tracking shorter than 3 clocks");

    a_no_track_conv: assert property (@(posedge clock) disable iff (rst) // [R12]
        state_q == ACC_CONV && $past(state_q) == ACC_CONV |-> !track_en)
        else $error("tracking during conversion");

    a_standby_off: assert property (@(posedge clock) disable iff (rst) // [R16]
        chip_standby |=> !track_en) else $error("tracking in standby");

    a_disable_idle: assert property (@(posedge clock) disable iff (rst) // [R19]
        !ctl_q.conv_enable |=> state_q == ACC_IDLE && !track_en)
        else $error("converter active while disabled");

    a_ljust_low_zero: assert property (@(posedge clock) disable iff (rst) // [R22]
        conv_last && ctl_q.left_justify |=> res_lo_q[5:0] == 6'h00)
        else $error("left-justified low bits not zero");

endmodule

// file: tb_acc_adc_control.sv
// self-checking bench of the converter control block
`timescale 1ns/1ps
`include "acc_defs.svh"

module tb_acc_adc_control
    import acc_pkg::*;
;
    logic       clock = 1'b0;
    logic       rst = 1'b1;
    logic [7:0] sfr_addr = 8'h00;
    logic       sfr_wr = 1'b0;
    logic       sfr_rd = 1'b0;
    logic [7:0] sfr_wdata = 8'h00;
    logic [7:0] sfr_rdata;
    logic       tmr3_ovf = 1'b0;
    logic       tmr2_ovf = 1'b0;
    logic       ext_conv_start = 1'b0;
    logic       comp_in = 1'b0;
    logic       diff_mode = 1'b0;
    logic       chip_standby = 1'b0;
    logic [9:0] dac_code;
    logic       sar_clk_tick;
    logic       track_en;
    logic       afe_enable;
    logic [2:0] pga_gain;
    logic       conv_irq;
    logic [9:0] target = 10'h000;
    logic [9:0] rv;
    logic [7:0] ctl = 8'h00;
    logic       seen_irq;
    logic       trk_bad;
    int         err_total = 0;
    int         checked = 0;
    int         cyc = 0;
    int         ticks;
    int         gap;
    int         gtab[8] = '{0, 1, 2, 3, 4, 4, 5, 5};
    int         ptab[5] = '{1, 2, 4, 8, 16};

    acc_adc_control acc_adc_control_inst (
        .clock, .rst, .sfr_addr, .sfr_wr, .sfr_rd, .sfr_wdata, .sfr_rdata,
        .tmr3_ovf, .tmr2_ovf, .ext_conv_start, .comp_in, .diff_mode, .chip_standby,
        .dac_code, .sar_clk_tick, .track_en, .afe_enable, .pga_gain, .conv_irq
    );

    always #10 clock = ~clock;

    // comparator stand-in: binary search converges on target
    always @(negedge clock)
        comp_in <= (target >= dac_code);

    always @(posedge clock)
    begin
        cyc = cyc + 1;
        if (cyc == 20000)
        begin
            err_total++;
            report_and_stop();
        end
    end

    task automatic report_and_stop();
        $display("checked %0d err_total %0d", checked, err_total);
        if (err_total == 0 && checked > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask

    task automatic chk(input logic [9:0] got, input logic [9:0] exp);
        checked++;
        if (got !== exp)
        begin
            err_total++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge clock);
        sfr_addr = a;
        sfr_wdata = d;
        sfr_wr = 1'b1;
        @(negedge clock);
        sfr_wr = 1'b0;
    endtask

    // rdata holds until the next read, so a late sample is safe
    task automatic rd(input logic [7:0] a);
        @(negedge clock);
        sfr_addr = a;
        sfr_rd = 1'b1;
        @(negedge clock);
        sfr_rd = 1'b0;
        @(negedge clock);
        rv = {2'b00, sfr_rdata};
    endtask

    task automatic chk_res(input logic [7:0] hi, input logic [7:0] lo);
        rd(`ACC_ADDR_RESULT_HI);
        chk(rv, {2'b00, hi});
        rd(`ACC_ADDR_RESULT_LO);
        chk(rv, {2'b00, lo});
    endtask

    task automatic trig(input logic [1:0] m);
        if (m == 2'b00)
            wr(`ACC_ADDR_CONTROL, ctl | 8'h10);
        else
        begin
            @(negedge clock);
            tmr3_ovf = (m == 2'b01);
            tmr2_ovf = (m == 2'b11);
            if (m == 2'b10)
                ext_conv_start = 1'b1;
            @(negedge clock);
            tmr3_ovf = 1'b0;
            tmr2_ovf = 1'b0;
        end
    endtask

    // gap ends up as the spacing of the last two sar clocks
    task automatic wait_done(input int n);
        int last;
        last = 0;
        ticks = 0;
        gap = 0;
        seen_irq = 1'b0;
        trk_bad = 1'b0;
        for (int i = 0; i < n && !seen_irq; i++)
        begin
            @(negedge clock);
            if (sar_clk_tick === 1'b1)
            begin
                gap = i - last;
                last = i;
                ticks++;
            end
            if (ticks > 0 && ticks < 10 && track_en !== 1'b0)
                trk_bad = 1'b1;
            seen_irq = (conv_irq === 1'b1);
        end
    endtask

    task automatic t_regs();
        rd(`ACC_ADDR_CONFIG);
        chk(rv, 10'h060);
        rd(`ACC_ADDR_CONTROL);
        chk(rv, 10'h000);
        rd(8'hBD);
        chk(rv, 10'h000);
        wr(`ACC_ADDR_CONFIG, 8'hFF);
        rd(`ACC_ADDR_CONFIG);
        chk(rv, 10'h0E7);
        for (int g = 0; g < 8; g++)
        begin
            wr(`ACC_ADDR_CONFIG, 8'(g));
            @(negedge clock);
            chk({7'h00, pga_gain}, 10'(gtab[g]));
        end
    endtask

    task automatic t_div();
        ctl = 8'h80;
        wr(`ACC_ADDR_CONTROL, ctl);
        for (int s = 0; s < 5; s++)
        begin
            wr(`ACC_ADDR_CONFIG, 8'(s << 5));
            target = 10'h155 + 10'(s * 97);
            trig(2'b00);
            wait_done(400);
            chk(10'(gap), 10'(ptab[s]));
            chk(10'(ticks), 10'd10);
            chk({9'h000, trk_bad}, 10'h000);
            chk_res({6'h00, target[9:8]}, target[7:0]);
        end
    endtask

    task automatic t_modes();
        wr(`ACC_ADDR_CONFIG, 8'h00);
        for (int m = 0; m < 4; m++)
        begin
            ctl = 8'h81 | 8'(m << 2);
            wr(`ACC_ADDR_CONTROL, ctl);
            target = 10'h3C6 - 10'(m);
            trig(2'(m));
            wait_done(100);
            chk({9'h000, seen_irq}, 10'h001);
            chk_res(target[9:2], {target[1:0], 6'h00});
            ext_conv_start = 1'b0;
        end
        // timer 3 overflow must not start while timer 2 is selected
        trig(2'b01);
        wait_done(60);
        chk({9'h000, seen_irq}, 10'h000);
    endtask

    task automatic t_track();
        for (int m = 0; m < 2; m++)
        begin
            ctl = 8'hC0 | 8'(m << 2);
            wr(`ACC_ADDR_CONTROL, ctl);
            trig(2'(m));
            wait_done(100);
            chk(10'(ticks), 10'd13);
        end
        ctl = 8'hC8;
        wr(`ACC_ADDR_CONTROL, ctl);
        repeat (4) @(negedge clock);
        chk({9'h000, track_en}, 10'h001);
        trig(2'b10);
        wait_done(100);
        chk({9'h000, track_en}, 10'h000);
        ext_conv_start = 1'b0;
        repeat (5) @(negedge clock);
        chk({9'h000, track_en}, 10'h001);
        chip_standby = 1'b1;
        repeat (3) @(negedge clock);
        chk({9'h000, track_en}, 10'h000);
        chip_standby = 1'b0;
    endtask

    task automatic t_misc();
        ctl = 8'h00;
        wr(`ACC_ADDR_CONTROL, ctl);
        trig(2'b00);
        wait_done(60);
        chk({9'h000, seen_irq}, 10'h000);
        chk({8'h00, afe_enable, track_en}, 10'h000);
        ctl = 8'h80;
        wr(`ACC_ADDR_CONTROL, ctl);
        wr(`ACC_ADDR_CONFIG, 8'h80);
        chk({9'h000, afe_enable}, 10'h001);
        trig(2'b00);
        rd(`ACC_ADDR_CONTROL);
        chk(rv, 10'h090);
        wait_done(400);
        rd(`ACC_ADDR_CONTROL);
        chk(rv, 10'h0A0);
        wr(`ACC_ADDR_CONTROL, ctl);
        rd(`ACC_ADDR_CONTROL);
        chk(rv, 10'h080);
        diff_mode = 1'b1;
        wr(`ACC_ADDR_CONFIG, 8'h00);
        target = 10'h0A5;
        trig(2'b00);
        wait_done(100);
        chk_res(8'hFE, 8'hA5);
        diff_mode = 1'b0;
    endtask

    initial
    begin
        repeat (10) @(negedge clock);
        rst = 1'b0;
        t_regs();
        t_div();
        t_modes();
        t_track();
        t_misc();
        report_and_stop();
    end
endmodule
